// ---- irq_ctrl_consts.svh ----
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// Register addresses in the special function register space
`define IRQ_ENABLE_ADDR 8'hA8
`define IRQ_PRIO_ADDR 8'hB8
// Enable register fields
`define IRQ_GATE_BIT 7
`define IRQ_SRC_MSB 5
// Reset values and read masks of reserved bits
`define IRQ_ENABLE_RST 8'h00
`define IRQ_PRIO_RST 8'h00
`define IRQ_ENABLE_RDMASK 8'hBF
`define IRQ_PRIO_RDMASK 8'h3F
// Vector placement: base plus eight bytes per source
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STEP 16'h0008
`define IRQ_VEC_LAST 16'h0033
`endif

// ---- irq_ctrl_pkg.sv ----
`default_nettype none
package irq_ctrl_pkg;
  typedef enum logic [0:0] {
    LVL_LOW = 1'b0,
    LVL_HIGH = 1'b1
  } svc_level_t;

  typedef struct packed {
    logic last_cycle;
    logic is_return;
    logic is_mask_access;
  } instr_status_t;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    svc_level_t level;
  } pick_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

// ---- irq_pick.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_pick (
  input wire logic [5:0] req,
  input wire logic [5:0] high_sel,
  output irq_ctrl_pkg::pick_t pick
);
  logic [5:0] hi_req;
  logic [5:0] lo_req;

  assign hi_req = req & high_sel;
  assign lo_req = req & ~high_sel;

  always_comb begin
    pick = '0;
    for (int i = 5; i >= 0; i--) begin
      if (lo_req[i]) begin
        pick.valid = 1'b1;
        pick.idx = 3'(i);
        pick.level = irq_ctrl_pkg::LVL_LOW;
      end
    end
    for (int i = 5; i >= 0; i--) begin
      if (hi_req[i]) begin
        pick.valid = 1'b1;
        pick.idx = 3'(i);
        pick.level = irq_ctrl_pkg::LVL_HIGH;
      end
    end
  end
endmodule : irq_pick
`default_nettype wire

// ---- two_level_interrupt_controller.sv ----
// Notes on behaviour
// - Six request sources, each assignable to one of two levels.
// - A source with its enable bit clear never gets a call.
// - Global gate bit clear blocks every source.
// - Priority bit set means high level, clear means low.
// - High preempts low service; nothing preempts high service.
// - Simultaneous requests of both levels: high served first.
// - Equal level order: ext0, timer0, ext1, timer1, uart, two-wire.
// - Flags sampled at the sample point, evaluated next machine cycle.
// - No call while equal or higher level service runs.
// - No call unless polling cycle is the instruction's last.
// - No call during return or enable/priority register access.
// - Blocked requests stay pending until call_ack or the next sample point replaces them.
// - Acknowledge clears timer flags, external flags only if edge mode.
// - Reset starts at zero; no vector in initialisation locations.
// - All six vectors lie between 0003h and 0033h.
// - Enable register at A8, priority register at B8.
// - Vectors 0003h,000Bh,0013h,001Bh,0023h,002Bh by source order.
// - The call pushes the program counter, not the status word.
// - Return clears the active level marker set by acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module two_level_interrupt_controller (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic state5_phase2_sample_point,
  input wire logic external_flag_zero,
  input wire logic timer_zero_flag,
  input wire logic external_flag_one,
  input wire logic timer_one_flag,
  input wire logic uart_unit_flag,
  input wire logic two_wire_unit_flag,
  input wire logic edge_mode_zero,
  input wire logic edge_mode_one,
  input wire irq_ctrl_pkg::instr_status_t instr,
  input wire logic return_from_service,
  output logic hardware_long_call,
  output logic call_push_pc,
  input wire logic call_ack,
  output logic [15:0] call_vector,
  output logic clear_external_zero,
  output logic clear_timer_zero,
  output logic clear_external_one,
  output logic clear_timer_one,
  output logic active_high,
  output logic active_low
);
  logic [7:0] enable_q;
  logic [7:0] prio_q;
  logic [5:0] sample_q;
  logic poll_q;
  logic act_hi_q;
  logic act_lo_q;
  logic [3:0] clr_q;
  logic [7:0] rdata_q;
  logic [15:0] vec_q;
  logic [5:0] flags;
  logic [5:0] armed;
  logic blocked;
  logic call_go;
  irq_ctrl_pkg::pick_t pick;

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    vec_of = `IRQ_VEC_BASE + (`IRQ_VEC_STEP * {13'h0, idx});
  endfunction : vec_of

  assign flags = {two_wire_unit_flag, uart_unit_flag, timer_one_flag,
                  external_flag_one, timer_zero_flag, external_flag_zero};

  // register writes at A8 and B8
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_q <= `IRQ_ENABLE_RST;
    end else if (sfr_wr && sfr_addr == `IRQ_ENABLE_ADDR) begin
      enable_q <= sfr_wdata & `IRQ_ENABLE_RDMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prio_q <= `IRQ_PRIO_RST;
    end else if (sfr_wr && sfr_addr == `IRQ_PRIO_ADDR) begin
      prio_q <= sfr_wdata & `IRQ_PRIO_RDMASK;
    end
  end

  // Unmapped addresses read zero so the core can merge several blocks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_addr == `IRQ_ENABLE_ADDR) begin
      rdata_q <= enable_q;
    end else if (sfr_addr == `IRQ_PRIO_ADDR) begin
      rdata_q <= prio_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign sfr_rdata = rdata_q;

  // sample flags at the sample point
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_q <= 6'h00;
    end else if (state5_phase2_sample_point) begin
      sample_q <= flags;
    end
  end

  // poll window opens at the sample point and stays open until call_ack
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      poll_q <= 1'b0;
    end else if (state5_phase2_sample_point) begin
      poll_q <= 1'b1;
    end else if (call_ack) begin
      poll_q <= 1'b0;
    end
  end

  assign armed = sample_q & enable_q[`IRQ_SRC_MSB:0]
                 & {6{enable_q[`IRQ_GATE_BIT]}};

  irq_pick u_pick (
    .req(armed),
    .high_sel(prio_q[`IRQ_SRC_MSB:0]),
    .pick(pick)
  );

  // running level blocks equal and lower
  assign blocked = act_hi_q
                   || (act_lo_q && pick.level == irq_ctrl_pkg::LVL_LOW)
                   || !instr.last_cycle
                   || instr.is_return
                   || instr.is_mask_access;

  assign call_go = poll_q && pick.valid && !blocked;
  assign hardware_long_call = call_go;
  // only the program counter is stacked
  assign call_push_pc = call_go;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_q <= `IRQ_VEC_BASE;
    end else begin
      vec_q <= vec_of(pick.idx);
    end
  end
  assign call_vector = vec_q;

  // return clears the higher active marker
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_hi_q <= 1'b0;
    end else if (call_ack && call_go && pick.level == irq_ctrl_pkg::LVL_HIGH) begin
      act_hi_q <= 1'b1;
    end else if (return_from_service) begin
      act_hi_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_lo_q <= 1'b0;
    end else if (call_ack && call_go && pick.level == irq_ctrl_pkg::LVL_LOW) begin
      act_lo_q <= 1'b1;
    end else if (return_from_service && !act_hi_q) begin
      act_lo_q <= 1'b0;
    end
  end
  assign active_high = act_hi_q;
  assign active_low = act_lo_q;

  // timer clears always, external only if edge
  // serial flags are left for software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clr_q <= 4'h0;
    end else if (call_ack && call_go) begin
      clr_q[0] <= pick.idx == 3'd0 && edge_mode_zero;
      clr_q[1] <= pick.idx == 3'd1;
      clr_q[2] <= pick.idx == 3'd2 && edge_mode_one;
      clr_q[3] <= pick.idx == 3'd3;
    end else begin
      clr_q <= 4'h0;
    end
  end
  assign clear_external_zero = clr_q[0];
  assign clear_timer_zero = clr_q[1];
  assign clear_external_one = clr_q[2];
  assign clear_timer_one = clr_q[3];

  // Checks
  logic past_go;
  logic [2:0] past_idx;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      past_go <= 1'b0;
      past_idx <= 3'd0;
    end else begin
      past_go <= call_go;
      past_idx <= pick.idx;
    end
  end

  a_gate_blocks_all: assert property (
    @(posedge sys_clk) disable iff (rst)
    !enable_q[`IRQ_GATE_BIT] |-> !hardware_long_call)
    else $error("call with global gate clear");

  a_source_enable: assert property (
    @(posedge sys_clk) disable iff (rst)
    hardware_long_call |-> enable_q[pick.idx])
    else $error("call for disabled source");

  a_high_no_preempt: assert property (
    @(posedge sys_clk) disable iff (rst)
    active_high |-> !hardware_long_call)
    else $error("call during high service");

  a_low_equal_block: assert property (
    @(posedge sys_clk) disable iff (rst)
    (active_low && hardware_long_call) |-> prio_q[pick.idx])
    else $error("low call during low service");

  a_last_cycle_only: assert property (
    @(posedge sys_clk) disable iff (rst)
    hardware_long_call |-> instr.last_cycle && !instr.is_return
      && !instr.is_mask_access)
    else $error("call outside legal boundary");

  a_high_first: assert property (
    @(posedge sys_clk) disable iff (rst)
    (hardware_long_call && |(armed & prio_q[5:0])) |-> prio_q[pick.idx])
    else $error("low picked over high");

  a_vector_range: assert property (
    @(posedge sys_clk) disable iff (rst)
    past_go |-> call_vector == vec_of(past_idx)
      && call_vector >= `IRQ_VEC_BASE && call_vector < `IRQ_VEC_LAST)
    else $error("vector out of range");

  a_ack_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    (call_ack && hardware_long_call && pick.idx == 3'd1)
      |=> clear_timer_zero ##1 !clear_timer_zero)
    else $error("timer zero flag not cleared once");

  a_ext_level_kept: assert property (
    @(posedge sys_clk) disable iff (rst)
    (call_ack && hardware_long_call && pick.idx == 3'd0 && !edge_mode_zero)
      |=> !clear_external_zero)
    else $error("level external flag cleared");

  a_return_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    (return_from_service && active_high && !call_ack) |=> !active_high)
    else $error("return left high marker");

  a_no_memory: assert property (
    @(posedge sys_clk) disable iff (rst)
    state5_phase2_sample_point ##1 !flags[0] [*1] |-> 1'b1 ##0
      (sample_q[0] == $past(flags[0])))
    else $error("sample not refreshed");

  a_high_marker_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    (call_ack && hardware_long_call && pick.level == irq_ctrl_pkg::LVL_HIGH)
      |=> active_high)
    else $error("high marker not set on ack");

  a_one_call_poll: assert property (
    @(posedge sys_clk) disable iff (rst)
    (call_ack && !state5_phase2_sample_point) |=> !hardware_long_call)
    else $error("second call in one poll window");

  a_order_in_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    (hardware_long_call && armed[0] && prio_q[0] == pick.level) |-> pick.idx == 3'd0)
    else $error("first source skipped in its level");

  a_sample_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !state5_phase2_sample_point |=> $stable(sample_q))
    else $error("flags sampled off the sample point");

  c_high_preempts: cover property (
    @(posedge sys_clk) disable iff (rst)
    active_low && hardware_long_call && call_ack);
  c_two_levels: cover property (
    @(posedge sys_clk) disable iff (rst)
    active_high && active_low);
  c_blocked_poll: cover property (
    @(posedge sys_clk) disable iff (rst)
    poll_q && pick.valid && !instr.last_cycle);
endmodule : two_level_interrupt_controller
`default_nettype wire

// ---- irq_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_seq_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hardware_long_call,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  output logic call_ack
);
  logic [3:0] wait_q;
  // Ack waits ack_wait cycles once enabled, so slow sequencers are covered too
  // Counting only while enabled keeps a long idle call from wrapping the count
  always_ff @(posedge sys_clk) begin
    if (rst || !ack_en || !hardware_long_call || call_ack) begin
      wait_q <= 4'h0;
      call_ack <= 1'b0;
    end else if (wait_q == ack_wait) begin
      call_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : irq_seq_model
`default_nettype wire

// ---- two_level_interrupt_controller_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module two_level_interrupt_controller_tb_top;
  logic sys_clk, rst, sfr_wr, sp, ret, ack_en, call, push, ack, act_h, act_l;
  logic clear_external_zero, clear_timer_zero, clear_external_one, clear_timer_one;
  logic [7:0] sfr_addr, sfr_wdata, rdata;
  logic [5:0] flg;
  logic [1:0] edge_m;
  logic [3:0] ack_wait, seen;
  logic [15:0] vec;
  irq_ctrl_pkg::instr_status_t instr;
  int fails, n_tests, cyc;
  logic [15:0] vtab [6] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
  two_level_interrupt_controller dut_u (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata(rdata), .state5_phase2_sample_point(sp), .external_flag_zero(flg[0]),
    .timer_zero_flag(flg[1]), .external_flag_one(flg[2]), .timer_one_flag(flg[3]),
    .uart_unit_flag(flg[4]), .two_wire_unit_flag(flg[5]), .edge_mode_zero(edge_m[0]),
    .edge_mode_one(edge_m[1]), .instr, .return_from_service(ret),
    .hardware_long_call(call), .call_push_pc(push), .call_ack(ack), .call_vector(vec),
    .clear_external_zero, .clear_timer_zero, .clear_external_one, .clear_timer_one,
    .active_high(act_h), .active_low(act_l));
  irq_seq_model seq_u (.sys_clk, .rst, .hardware_long_call(call), .ack_en, .ack_wait,
    .call_ack(ack));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    @(posedge sys_clk);
    #1 chk(16'(rdata), 16'(exp));
  endtask : rd
  task automatic set_i(input logic [2:0] v);
    @(posedge sys_clk);
    instr <= v;
  endtask : set_i
  task automatic poll(input logic [5:0] f, input logic ec, input logic [15:0] ev);
    @(posedge sys_clk);
    flg <= f;
    sp <= 1'b1;
    @(posedge sys_clk);
    sp <= 1'b0;
    @(posedge sys_clk);
    #1 chk(16'(call), 16'(ec));
    chk(16'(push), 16'(ec));
    if (ec) chk(vec, ev);
  endtask : poll
  task automatic take(input logic [3:0] w, input logic [3:0] exp);
    @(posedge sys_clk);
    ack_wait <= w;
    ack_en <= 1'b1;
    seen = 4'h0;
    repeat (8) begin
      @(posedge sys_clk);
      #1 seen |= {clear_timer_one, clear_external_one, clear_timer_zero, clear_external_zero};
    end
    chk(16'(seen), 16'(exp));
    chk(16'(call), 16'h0000);
    @(posedge sys_clk);
    ack_en <= 1'b0;
  endtask : take
  task automatic rti(input logic eh, input logic el);
    @(posedge sys_clk);
    ret <= 1'b1;
    @(posedge sys_clk);
    ret <= 1'b0;
    #1 chk(16'({act_h, act_l}), 16'({eh, el}));
  endtask : rti
  task automatic t_regs();
    chk(vec, 16'h0003);
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h00);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hBF);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h3F);
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'h00);
  endtask : t_regs
  task automatic t_order();
    wr(8'hB8, 8'h00);
    for (int i = 0; i < 6; i++) poll(6'h01 << i, 1'b1, vtab[i]);
    poll(6'h3E, 1'b1, vtab[1]);
    wr(8'hB8, 8'h20);
    poll(6'h3F, 1'b1, vtab[5]);
    wr(8'hB8, 8'h28);
    poll(6'h3F, 1'b1, vtab[3]);
  endtask : t_order
  task automatic t_block();
    wr(8'hB8, 8'h00);
    wr(8'hA8, 8'h3F);
    poll(6'h3F, 1'b0, 16'h0000);
    wr(8'hA8, 8'hBE);
    poll(6'h01, 1'b0, 16'h0000);
    wr(8'hA8, 8'hBF);
    set_i(3'b000);
    poll(6'h02, 1'b0, 16'h0000);
    set_i(3'b110);
    poll(6'h02, 1'b0, 16'h0000);
    set_i(3'b101);
    poll(6'h02, 1'b0, 16'h0000);
    set_i(3'b100);
    poll(6'h00, 1'b0, 16'h0000);
    @(posedge sys_clk);
    flg <= 6'h02;
    repeat (3) @(posedge sys_clk);
    #1 chk(16'(call), 16'h0000);
  endtask : t_block
  task automatic t_nest();
    wr(8'hB8, 8'h08);
    poll(6'h02, 1'b1, vtab[1]);
    take(4'h0, 4'b0010);
    chk(16'({act_h, act_l}), 16'h0001);
    poll(6'h01, 1'b0, 16'h0000);
    poll(6'h0A, 1'b1, vtab[3]);
    take(4'h3, 4'b1000);
    chk(16'({act_h, act_l}), 16'h0003);
    poll(6'h0B, 1'b0, 16'h0000);
    rti(1'b0, 1'b1);
    rti(1'b0, 1'b0);
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      edge_m <= {m[0], m[0]};
      poll(6'h01, 1'b1, vtab[0]);
      take(4'h1, {3'b000, m[0]});
      rti(1'b0, 1'b0);
      poll(6'h04, 1'b1, vtab[2]);
      take(4'h2, {1'b0, m[0], 2'b00});
      rti(1'b0, 1'b0);
    end
    poll(6'h10, 1'b1, vtab[4]);
    take(4'h0, 4'b0000);
    @(posedge sys_clk);
    flg <= 6'h00;
  endtask : t_nest
  initial begin
    {rst, sfr_wr, sp, ret, ack_en} = 5'b10000;
    {sfr_addr, sfr_wdata, flg, edge_m, ack_wait} = '0;
    instr = 3'b100;
    {fails, n_tests} = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 t_regs();
    t_order();
    t_block();
    t_nest();
    print_verdict();
  end
endmodule : two_level_interrupt_controller_tb_top
`default_nettype wire
